// ===== src/dfsb_chan_check.sv
`timescale 1ns/10ps
module dfsb_chan_check #(
    parameter int RD_W = 16,
    parameter int THR_W = 5,
    parameter int SHIFT = 4
) (
    input wire logic [RD_W-1:0] main_rd,
    input wire logic [RD_W-1:0] aux_rd,
    input wire logic [THR_W-1:0] cmp_thr,
    input wire logic [THR_W-1:0] open_thr,
    output logic cmp_fail,
    output logic ow_fail
);
    localparam int EXT_W = RD_W + THR_W + SHIFT;

    if (SHIFT < 0 || SHIFT > RD_W) begin : g_bad_shift
        $error("dfsb_chan_check: SHIFT out of range");
    end

    logic [EXT_W-1:0] diff;
    logic [EXT_W-1:0] cmp_lim;
    logic [EXT_W-1:0] ow_lim;

    always_comb begin
        if (main_rd >= aux_rd) begin
            diff = EXT_W'(main_rd - aux_rd);
        end else begin
            diff = EXT_W'(aux_rd - main_rd);
        end
        // Threshold codes count in steps of 2**SHIFT reading units
        cmp_lim = EXT_W'(cmp_thr) << SHIFT;
        ow_lim = EXT_W'(open_thr) << SHIFT;
        cmp_fail = diff > cmp_lim;
        ow_fail = EXT_W'(main_rd) < ow_lim;
    end
endmodule

// ===== src/dfsb_pkg.sv
package dfsb_pkg;
    localparam int RD_W = 16;
    localparam int N_IN = 8;
    localparam int N_CELL = 16;
    localparam int N_EV = 6;
    localparam int IDX_W = 14;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_UNDERTEMP_FLAGS = 14'h0541;
    localparam logic [IDX_W-1:0] IDX_INPUT_COMPARE_FAIL = 14'h0543;
    localparam logic [IDX_W-1:0] IDX_CELL_COMPARE_FAIL_HI = 14'h0545;
    localparam logic [IDX_W-1:0] IDX_CELL_COMPARE_FAIL_LO = 14'h0546;
    localparam logic [IDX_W-1:0] IDX_SENSE_OPEN_WIRE_FAIL_HI = 14'h0548;
    localparam logic [IDX_W-1:0] IDX_SENSE_OPEN_WIRE_FAIL_LO = 14'h0549;
    localparam logic [IDX_W-1:0] IDX_BALANCE_OPEN_WIRE_FAIL_HI = 14'h054b;
    localparam logic [IDX_W-1:0] IDX_BALANCE_OPEN_WIRE_FAIL_LO = 14'h054c;
    localparam logic [IDX_W-1:0] IDX_BALANCE_SWITCH_FAIL_HI = 14'h054e;
    localparam logic [IDX_W-1:0] IDX_BALANCE_SWITCH_FAIL_LO = 14'h054f;
    localparam logic [IDX_W-1:0] IDX_THRESHOLD_CTRL = 14'h0560;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 14'h0561;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 14'h0562;

    // Threshold control fields
    localparam int IN_THR_LSB = 0;
    localparam int IN_THR_W = 3;
    localparam int CELL_THR_LSB = 3;
    localparam int CELL_THR_W = 5;
    localparam int OPEN_THR_LSB = 8;
    localparam int OPEN_THR_W = 4;
    localparam int CTRL_W = 12;
    localparam int THR_W = 5;

    localparam logic [7:0] FAULT_RST = 8'h00;
    localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
    localparam logic [N_EV-1:0] EV_RST = 6'h00;

    // Event bits of the interrupt status and mask registers
    typedef enum logic [2:0] {
        EV_UNDERTEMP = 3'h0,
        EV_INPUT_CMP = 3'h1,
        EV_CELL_CMP = 3'h2,
        EV_SENSE_OW = 3'h3,
        EV_BAL_OW = 3'h4,
        EV_BAL_SW = 3'h5
    } dfsb_event_t;

    typedef struct packed {
        logic [N_CELL-1:0][RD_W-1:0] main_rd;
        logic [N_CELL-1:0][RD_W-1:0] aux_rd;
    } dfsb_cell_rd_t;

    typedef struct packed {
        logic [N_IN-1:0][RD_W-1:0] main_rd;
        logic [N_IN-1:0][RD_W-1:0] aux_rd;
    } dfsb_in_rd_t;
endpackage

// ===== src/dfsb_top.sv
`timescale 1ns/10ps
module dfsb_top #(
    parameter int THR_SHIFT = 4
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [dfsb_pkg::ADDR_W-1:0] PADDR,
    input wire logic [dfsb_pkg::DATA_W-1:0] PWDATA,
    output logic [dfsb_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire dfsb_pkg::dfsb_cell_rd_t CELL_RD,
    input wire dfsb_pkg::dfsb_in_rd_t INPUT_RD,
    input wire logic CELL_CMP_DONE,
    input wire logic INPUT_CMP_DONE,
    input wire logic SENSE_OW_DONE,
    input wire logic [dfsb_pkg::N_IN-1:0] UNDERTEMP_RAW,
    input wire logic [dfsb_pkg::N_CELL-1:0] BAL_OW_RAW,
    input wire logic BAL_OW_DONE,
    input wire logic [dfsb_pkg::N_CELL-1:0] BAL_SW_RAW,
    input wire logic BAL_SW_DONE
);
    localparam int N_IN = dfsb_pkg::N_IN;
    localparam int N_CELL = dfsb_pkg::N_CELL;
    localparam int N_EV = dfsb_pkg::N_EV;
    localparam int SYNC_W = N_IN + 2 * N_CELL;
    // Upper register of a cell bank holds channels N_IN+1 to N_CELL
    localparam int HI_LSB = N_IN;

    if (THR_SHIFT < 0 || THR_SHIFT > dfsb_pkg::RD_W) begin : g_bad_shift
        $error("dfsb_top: THR_SHIFT out of range");
    end

    // Register slices assume two byte-wide halves per cell bank
    if (N_CELL != 2 * N_IN || N_IN != $bits(dfsb_pkg::FAULT_RST)) begin : g_bad_chan
        $error("dfsb_top: channel counts do not fit byte registers");
    end

    if (dfsb_pkg::IDX_W != dfsb_pkg::ADDR_W - 2) begin : g_bad_idx
        $error("dfsb_top: index width must drop the byte offset");
    end

    // Narrower threshold fields are zero-extended, wider ones would be cut
    if (dfsb_pkg::IN_THR_W > dfsb_pkg::THR_W || dfsb_pkg::CELL_THR_W > dfsb_pkg::THR_W
        || dfsb_pkg::OPEN_THR_W > dfsb_pkg::THR_W) begin : g_bad_thr
        $error("dfsb_top: threshold field wider than comparator input");
    end

    if (dfsb_pkg::OPEN_THR_LSB + dfsb_pkg::OPEN_THR_W > dfsb_pkg::CTRL_W) begin : g_bad_ctrl
        $error("dfsb_top: threshold fields overflow the control register");
    end

    if (dfsb_pkg::CTRL_W > dfsb_pkg::DATA_W || N_EV > dfsb_pkg::DATA_W) begin : g_bad_data
        $error("dfsb_top: register wider than the data bus");
    end

    if (N_EV != int'(dfsb_pkg::EV_BAL_SW) + 1) begin : g_bad_ev
        $error("dfsb_top: event count does not match the event list");
    end

    // Pin synchronisers; raw comparator levels come from the analog side
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] sync1_d;
    logic [SYNC_W-1:0] sync2_d;
    logic [N_IN-1:0] undertemp_sync;
    logic [N_CELL-1:0] bal_ow_sync;
    logic [N_CELL-1:0] bal_sw_sync;

    always_comb begin
        sync1_d = {UNDERTEMP_RAW, BAL_OW_RAW, BAL_SW_RAW};
        sync2_d = sync1_q;
        undertemp_sync = sync2_q[SYNC_W-1 -: N_IN];
        bal_ow_sync = sync2_q[2*N_CELL-1 -: N_CELL];
        bal_sw_sync = sync2_q[N_CELL-1:0];
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // Threshold control, written by software
    logic [dfsb_pkg::CTRL_W-1:0] ctrl_q;
    logic [dfsb_pkg::CTRL_W-1:0] ctrl_d;
    logic [dfsb_pkg::THR_W-1:0] in_thr;
    logic [dfsb_pkg::THR_W-1:0] cell_thr;
    logic [dfsb_pkg::THR_W-1:0] open_thr;

    always_comb begin
        in_thr = dfsb_pkg::THR_W'(ctrl_q[dfsb_pkg::IN_THR_LSB +: dfsb_pkg::IN_THR_W]);
        cell_thr = dfsb_pkg::THR_W'(ctrl_q[dfsb_pkg::CELL_THR_LSB +: dfsb_pkg::CELL_THR_W]);
        open_thr = dfsb_pkg::THR_W'(ctrl_q[dfsb_pkg::OPEN_THR_LSB +: dfsb_pkg::OPEN_THR_W]);
    end

    // Per-channel comparisons
    logic [N_CELL-1:0] cell_cmp_res;
    logic [N_CELL-1:0] sense_ow_res;
    logic [N_IN-1:0] in_cmp_res;

    for (genvar i = 0; i < N_CELL; i++) begin : g_cell
        dfsb_chan_check #(
            .RD_W(dfsb_pkg::RD_W),
            .THR_W(dfsb_pkg::THR_W),
            .SHIFT(THR_SHIFT)
        ) u_chk (
            .main_rd(CELL_RD.main_rd[i]),
            .aux_rd(CELL_RD.aux_rd[i]),
            .cmp_thr(cell_thr),
            .open_thr(open_thr),
            .cmp_fail(cell_cmp_res[i]),
            .ow_fail(sense_ow_res[i])
        );
    end

    for (genvar i = 0; i < N_IN; i++) begin : g_in
        dfsb_chan_check #(
            .RD_W(dfsb_pkg::RD_W),
            .THR_W(dfsb_pkg::THR_W),
            .SHIFT(THR_SHIFT)
        ) u_chk (
            .main_rd(INPUT_RD.main_rd[i]),
            .aux_rd(INPUT_RD.aux_rd[i]),
            .cmp_thr(in_thr),
            .open_thr('0),
            .cmp_fail(in_cmp_res[i]),
            .ow_fail()
        );
    end

    // Fault status, bit n-1 holds channel n
    logic [N_IN-1:0] undertemp_q;
    logic [N_IN-1:0] undertemp_d;
    logic [N_IN-1:0] in_cmp_q;
    logic [N_IN-1:0] in_cmp_d;
    logic [N_CELL-1:0] cell_cmp_q;
    logic [N_CELL-1:0] cell_cmp_d;
    logic [N_CELL-1:0] sense_ow_q;
    logic [N_CELL-1:0] sense_ow_d;
    logic [N_CELL-1:0] bal_ow_q;
    logic [N_CELL-1:0] bal_ow_d;
    logic [N_CELL-1:0] bal_sw_q;
    logic [N_CELL-1:0] bal_sw_d;
    logic [N_EV-1:0] event_set;

    always_comb begin
        // Undertemperature follows its comparator; the rest latch on a done strobe
        undertemp_d = undertemp_sync;
        in_cmp_d = INPUT_CMP_DONE ? in_cmp_res : in_cmp_q;
        cell_cmp_d = CELL_CMP_DONE ? cell_cmp_res : cell_cmp_q;
        sense_ow_d = SENSE_OW_DONE ? sense_ow_res : sense_ow_q;
        bal_ow_d = BAL_OW_DONE ? bal_ow_sync : bal_ow_q;
        bal_sw_d = BAL_SW_DONE ? bal_sw_sync : bal_sw_q;
        // A new failure on any channel is one event
        event_set = '0;
        event_set[dfsb_pkg::EV_UNDERTEMP] = |(undertemp_d & ~undertemp_q);
        event_set[dfsb_pkg::EV_INPUT_CMP] = |(in_cmp_d & ~in_cmp_q);
        event_set[dfsb_pkg::EV_CELL_CMP] = |(cell_cmp_d & ~cell_cmp_q);
        event_set[dfsb_pkg::EV_SENSE_OW] = |(sense_ow_d & ~sense_ow_q);
        event_set[dfsb_pkg::EV_BAL_OW] = |(bal_ow_d & ~bal_ow_q);
        event_set[dfsb_pkg::EV_BAL_SW] = |(bal_sw_d & ~bal_sw_q);
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            undertemp_q <= dfsb_pkg::FAULT_RST;
            in_cmp_q <= dfsb_pkg::FAULT_RST;
            cell_cmp_q <= {dfsb_pkg::FAULT_RST, dfsb_pkg::FAULT_RST};
            sense_ow_q <= {dfsb_pkg::FAULT_RST, dfsb_pkg::FAULT_RST};
            bal_ow_q <= {dfsb_pkg::FAULT_RST, dfsb_pkg::FAULT_RST};
            bal_sw_q <= {dfsb_pkg::FAULT_RST, dfsb_pkg::FAULT_RST};
        end else begin
            undertemp_q <= undertemp_d;
            in_cmp_q <= in_cmp_d;
            cell_cmp_q <= cell_cmp_d;
            sense_ow_q <= sense_ow_d;
            bal_ow_q <= bal_ow_d;
            bal_sw_q <= bal_sw_d;
        end
    end

    // APB slave; read data is fetched in the setup cycle so access needs no wait
    logic [dfsb_pkg::IDX_W-1:0] idx;
    logic setup;
    logic wr_commit;
    logic [N_EV-1:0] sts_q;
    logic [N_EV-1:0] sts_d;
    logic [N_EV-1:0] mask_q;
    logic [N_EV-1:0] mask_d;
    logic [dfsb_pkg::DATA_W-1:0] rdata_q;
    logic [dfsb_pkg::DATA_W-1:0] rdata_d;
    logic ready_q;
    logic ready_d;
    logic err_q;
    logic err_d;
    logic irq_q;
    logic irq_d;
    logic [7:0] rd_byte;
    logic hit;

    always_comb begin
        idx = PADDR[dfsb_pkg::ADDR_W-1:2];
        setup = PSEL && !PENABLE;
        wr_commit = PSEL && PENABLE && ready_q && PWRITE && !err_q;
        rd_byte = 8'h00;
        hit = 1'b1;
        rdata_d = rdata_q;
        case (idx)
            dfsb_pkg::IDX_UNDERTEMP_FLAGS: rd_byte = undertemp_q;
            dfsb_pkg::IDX_INPUT_COMPARE_FAIL: rd_byte = in_cmp_q;
            dfsb_pkg::IDX_CELL_COMPARE_FAIL_HI: rd_byte = cell_cmp_q[N_CELL-1:HI_LSB];
            dfsb_pkg::IDX_CELL_COMPARE_FAIL_LO: rd_byte = cell_cmp_q[HI_LSB-1:0];
            dfsb_pkg::IDX_SENSE_OPEN_WIRE_FAIL_HI: rd_byte = sense_ow_q[N_CELL-1:HI_LSB];
            dfsb_pkg::IDX_SENSE_OPEN_WIRE_FAIL_LO: rd_byte = sense_ow_q[HI_LSB-1:0];
            dfsb_pkg::IDX_BALANCE_OPEN_WIRE_FAIL_HI: rd_byte = bal_ow_q[N_CELL-1:HI_LSB];
            dfsb_pkg::IDX_BALANCE_OPEN_WIRE_FAIL_LO: rd_byte = bal_ow_q[HI_LSB-1:0];
            dfsb_pkg::IDX_BALANCE_SWITCH_FAIL_HI: rd_byte = bal_sw_q[N_CELL-1:HI_LSB];
            dfsb_pkg::IDX_BALANCE_SWITCH_FAIL_LO: rd_byte = bal_sw_q[HI_LSB-1:0];
            dfsb_pkg::IDX_THRESHOLD_CTRL, dfsb_pkg::IDX_IRQ_STATUS,
            dfsb_pkg::IDX_IRQ_MASK: rd_byte = 8'h00;
            default: hit = 1'b0;
        endcase
        if (setup) begin
            if (idx == dfsb_pkg::IDX_THRESHOLD_CTRL) begin
                rdata_d = dfsb_pkg::DATA_W'(ctrl_q);
            end else if (idx == dfsb_pkg::IDX_IRQ_STATUS) begin
                rdata_d = dfsb_pkg::DATA_W'(sts_q);
            end else if (idx == dfsb_pkg::IDX_IRQ_MASK) begin
                rdata_d = dfsb_pkg::DATA_W'(mask_q);
            end else begin
                rdata_d = dfsb_pkg::DATA_W'(rd_byte);
            end
        end
        // Zero wait: ready in the first access cycle, error only alongside it
        ready_d = setup;
        err_d = setup && !hit;
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rdata_q <= '0;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    // Software registers; writes to fault registers are accepted and dropped
    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        sts_d = sts_q;
        if (wr_commit && idx == dfsb_pkg::IDX_THRESHOLD_CTRL) begin
            ctrl_d = PWDATA[dfsb_pkg::CTRL_W-1:0];
        end
        if (wr_commit && idx == dfsb_pkg::IDX_IRQ_MASK) begin
            mask_d = PWDATA[N_EV-1:0];
        end
        if (wr_commit && idx == dfsb_pkg::IDX_IRQ_STATUS) begin
            sts_d = sts_q & ~PWDATA[N_EV-1:0];
        end
        // Set after clear so a same-cycle event is kept
        sts_d = sts_d | event_set;
        irq_d = |(sts_d & mask_d);
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ctrl_q <= dfsb_pkg::CTRL_RST;
            sts_q <= dfsb_pkg::EV_RST;
            mask_q <= dfsb_pkg::EV_RST;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            sts_q <= sts_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign PRDATA = rdata_q;
    assign PREADY = ready_q;
    assign PSLVERR = err_q;
    assign IRQ = irq_q;
endmodule

// ===== test/dfsb_top_assertions.sv
`timescale 1ns/10ps
module dfsb_chk (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [dfsb_pkg::ADDR_W-1:0] PADDR,
    input wire logic [dfsb_pkg::DATA_W-1:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ,
    input wire logic [dfsb_pkg::N_IN-1:0] UNDERTEMP_RAW
);
    logic [dfsb_pkg::IDX_W-1:0] idx;
    logic flt;
    assign idx = PADDR[15:2];
    assign flt = idx inside {14'h0541, 14'h0543, 14'h0545, 14'h0546, 14'h0548,
        14'h0549, 14'h054b, 14'h054c, 14'h054e, 14'h054f};
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_done;
        PSEL && PENABLE && PREADY;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> s_done)
        else $error("ready not in first access cycle");
    a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    a_fault_no_error: assert property (PREADY && flt |-> !PSLVERR)
        else $error("error on status register");
    a_fault_upper_zero: assert property (s_done and (flt && !PWRITE)
        |-> PRDATA[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
        else $error("read data moved without setup");
    a_undertemp_live: assert property (s_done and (!PWRITE && idx == 14'h0541
        && $past(RST_B, 6) && UNDERTEMP_RAW == $past(UNDERTEMP_RAW, 6))
        |-> PRDATA[7:0] == UNDERTEMP_RAW)
        else $error("undertemp flags do not follow inputs");
    a_irq_low_after_reset: assert property ($rose(RST_B) |-> !IRQ)
        else $error("interrupt high after reset");
endmodule
bind dfsb_top dfsb_chk u_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IRQ(IRQ), .UNDERTEMP_RAW(UNDERTEMP_RAW));

// ===== test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
    logic [15:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    dfsb_pkg::dfsb_cell_rd_t cell_rd;
    dfsb_pkg::dfsb_in_rd_t in_rd;
    logic [4:0] done;
    logic [7:0] undertemp_raw;
    logic [15:0] ow_raw, sw_raw;
    int mismatches = 0;
    int n_compared = 0;
    always #25 CLK = ~CLK;
    dfsb_top dut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .IRQ(IRQ), .CELL_RD(cell_rd), .INPUT_RD(in_rd), .CELL_CMP_DONE(done[0]),
        .INPUT_CMP_DONE(done[1]), .SENSE_OW_DONE(done[2]), .UNDERTEMP_RAW(undertemp_raw),
        .BAL_OW_RAW(ow_raw), .BAL_OW_DONE(done[3]), .BAL_SW_RAW(sw_raw), .BAL_SW_DONE(done[4]));
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        int n;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= {idx, 2'b00};
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        rd = PRDATA;
        err = PSLVERR;
        if (PREADY !== 1'b1) begin
            mismatches++;
            print_verdict();
        end else begin
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
            @(posedge CLK);
        end
    endtask
    task automatic rdchk(input string name, input logic [13:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 32'h0000_0000, rd, err);
        chk(name, exp, rd);
    endtask
    task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, wd, rd, err);
    endtask
    task automatic pulse(input int b);
        done[b] <= 1'b1;
        @(posedge CLK);
        done[b] <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic t_reset_ro;
        logic [13:0] f [10] = '{14'h0541, 14'h0543, 14'h0545, 14'h0546, 14'h0548,
            14'h0549, 14'h054b, 14'h054c, 14'h054e, 14'h054f};
        foreach (f[i]) begin
            rdchk("fault reset", f[i], 32'h0000_0000);
            wr(f[i], 32'hffff_ffff);
            rdchk("fault write", f[i], 32'h0000_0000);
        end
    endtask
    task automatic t_undertemp;
        logic [7:0] v [3] = '{8'h81, 8'h7e, 8'h00};
        foreach (v[i]) begin
            undertemp_raw <= v[i];
            repeat (6) @(posedge CLK);
            rdchk("undertemp", dfsb_pkg::IDX_UNDERTEMP_FLAGS, {24'h00_0000, v[i]});
        end
    endtask
    task automatic t_input_cmp;
        // Step 16: input limit 16, cell 32, open-wire 48
        wr(dfsb_pkg::IDX_THRESHOLD_CTRL, 32'h0000_0311);
        in_rd.aux_rd[0] <= 16'h03f8;
        in_rd.aux_rd[1] <= 16'h03d7;
        in_rd.aux_rd[7] <= 16'h03f9;
        pulse(1);
        rdchk("input cmp", dfsb_pkg::IDX_INPUT_COMPARE_FAIL, 32'h0000_0082);
    endtask
    task automatic t_cell;
        cell_rd.aux_rd[0] <= 16'h0409;
        cell_rd.aux_rd[8] <= 16'h0408;
        cell_rd.aux_rd[15] <= 16'h0410;
        cell_rd.main_rd[9] <= 16'h0409;
        pulse(0);
        rdchk("cell hi", dfsb_pkg::IDX_CELL_COMPARE_FAIL_HI, 32'h0000_0082);
        rdchk("cell lo", dfsb_pkg::IDX_CELL_COMPARE_FAIL_LO, 32'h0000_0001);
    endtask
    task automatic t_sense_ow;
        cell_rd.main_rd[15] <= 16'h002f;
        cell_rd.main_rd[7] <= 16'h0030;
        cell_rd.main_rd[0] <= 16'h0000;
        pulse(2);
        rdchk("sense hi", dfsb_pkg::IDX_SENSE_OPEN_WIRE_FAIL_HI, 32'h0000_0080);
        rdchk("sense lo", dfsb_pkg::IDX_SENSE_OPEN_WIRE_FAIL_LO, 32'h0000_0001);
    endtask
    task automatic t_bal;
        ow_raw <= 16'h8001;
        sw_raw <= 16'h0180;
        repeat (3) @(posedge CLK);
        pulse(3);
        rdchk("bal ow hi", dfsb_pkg::IDX_BALANCE_OPEN_WIRE_FAIL_HI, 32'h0000_0080);
        rdchk("bal ow lo", dfsb_pkg::IDX_BALANCE_OPEN_WIRE_FAIL_LO, 32'h0000_0001);
        pulse(4);
        rdchk("bal sw hi", dfsb_pkg::IDX_BALANCE_SWITCH_FAIL_HI, 32'h0000_0001);
        rdchk("bal sw lo", dfsb_pkg::IDX_BALANCE_SWITCH_FAIL_LO, 32'h0000_0080);
    endtask
    task automatic t_irq;
        logic [31:0] rd;
        logic err;
        rdchk("status", dfsb_pkg::IDX_IRQ_STATUS, 32'h0000_003f);
        chk("irq masked", 32'h0000_0000, {31'h0000_0000, IRQ});
        wr(dfsb_pkg::IDX_IRQ_MASK, 32'h0000_0004);
        chk("irq raised", 32'h0000_0001, {31'h0000_0000, IRQ});
        wr(dfsb_pkg::IDX_IRQ_STATUS, 32'h0000_003f);
        chk("irq cleared", 32'h0000_0000, {31'h0000_0000, IRQ});
        apb(1'b0, 14'h0542, 32'h0000_0000, rd, err);
        chk("unmapped err", 32'h0000_0001, {31'h0000_0000, err});
    endtask
    task automatic t_mid_reset;
        wr(dfsb_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        undertemp_raw <= 8'h01;
        repeat (6) @(posedge CLK);
        chk("irq before reset", 32'h0000_0001, {31'h0000_0000, IRQ});
        undertemp_raw <= 8'h00;
        RST_B <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        chk("irq after reset", 32'h0000_0000, {31'h0000_0000, IRQ});
        rdchk("ctrl reset", dfsb_pkg::IDX_THRESHOLD_CTRL, 32'h0000_0000);
        rdchk("mask reset", dfsb_pkg::IDX_IRQ_MASK, 32'h0000_0000);
        rdchk("status reset", dfsb_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
        rdchk("cell hi reset", dfsb_pkg::IDX_CELL_COMPARE_FAIL_HI, 32'h0000_0000);
        rdchk("sense lo reset", dfsb_pkg::IDX_SENSE_OPEN_WIRE_FAIL_LO, 32'h0000_0000);
        rdchk("bal ow hi reset", dfsb_pkg::IDX_BALANCE_OPEN_WIRE_FAIL_HI, 32'h0000_0000);
        rdchk("bal sw lo reset", dfsb_pkg::IDX_BALANCE_SWITCH_FAIL_LO, 32'h0000_0000);
    endtask
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, done, undertemp_raw, ow_raw, sw_raw} = '0;
        for (int i = 0; i < 16; i++) begin
            cell_rd.main_rd[i] = 16'h03e8;
            cell_rd.aux_rd[i] = 16'h03e8;
        end
        for (int i = 0; i < 8; i++) begin
            in_rd.main_rd[i] = 16'h03e8;
            in_rd.aux_rd[i] = 16'h03e8;
        end
        repeat (8) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        t_reset_ro();
        t_undertemp();
        t_input_cmp();
        t_cell();
        t_sense_ow();
        t_bal();
        t_irq();
        t_mid_reset();
        print_verdict();
    end
endmodule
